/* File: core/clock_fail_monitor_ref_trim.sv */
// Clock failure monitor with fallback switch, NMI and reference trim register
// What this block does
// [R1] On a main clock stop the core clock moves to the internal fast RC.
// [R2] A detected clock stop also raises a non-maskable interrupt.
// [R3] In sleep the monitor halts, so no detection or switchover happens.
// [R4] Trim is a nine-bit field at bits 31:23, zero at reset; 22:0 read zero.
// [R5] While the output is on, new trim applies only on a divider switch.
// [R6] Software must not write trim while output enable and active differ.
// [R7] Trim has no effect on the reference output while the divisor is zero.
module clock_fail_monitor_ref_trim
    import clock_fail_monitor_ref_trim_pkg::*;
#(
    parameter int unsigned FAIL_TIMEOUT = FAIL_TIMEOUT_DEF
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic main_clk_i,
    input wire logic sleep_i,
    input wire logic ref_active_i,
    output logic clk_sel_frc_o,
    output logic nmi_o,
    output logic irq_o,
    output logic ref_on_o,
    output logic [DIV_W-1:0] ref_div_o,
    output logic [TRIM_W-1:0] ref_trim_o,
    output logic ref_div_switch_o
);
    if (FAIL_TIMEOUT < 2 || FAIL_TIMEOUT >= (1 << CNT_W)) begin : g_chk
        $error("FAIL_TIMEOUT out of range");
    end

    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(FAIL_TIMEOUT - 1);

    state_t s_ff;
    state_t nxt_s;

    logic req;
    logic wr;
    logic mclk_edge;
    logic fail_evt;
    logic viol_evt;
    logic [31:0] wmask;
    logic [31:0] trim_img;
    logic [31:0] ctrl_img;
    logic [31:0] trim_new;
    logic [31:0] ctrl_new;
    logic [EVT_W-1:0] evt;
    logic [EVT_W-1:0] w1c;

    always_comb begin
        nxt_s = s_ff;
        req = cyc_i && stb_i && !s_ff.ack;
        wr = req && we_i;
        wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
        trim_img = {s_ff.trim_reg, 23'h00_0000};
        ctrl_img = 32'h0000_0000;
        ctrl_img[CTRL_DIV_LSB +: DIV_W] = s_ff.div;
        ctrl_img[CTRL_ON_BIT] = s_ff.on;
        ctrl_img[CTRL_DIVSW_BIT] = s_ff.divsw;
        trim_new = (trim_img & ~wmask) | (dat_i & wmask);
        ctrl_new = (ctrl_img & ~wmask) | (dat_i & wmask);
        fail_evt = 1'b0;
        viol_evt = 1'b0;
        w1c = '0;

        // Pin inputs: a change counts once the second and third stage agree
        nxt_s.mclk_sync = {s_ff.mclk_sync[1:0], main_clk_i};
        nxt_s.sleep_sync = {s_ff.sleep_sync[1:0], sleep_i};
        nxt_s.act_sync = {s_ff.act_sync[1:0], ref_active_i};
        if (s_ff.mclk_sync[1] == s_ff.mclk_sync[2]) begin
            nxt_s.mclk_lvl = s_ff.mclk_sync[2];
        end
        if (s_ff.sleep_sync[1] == s_ff.sleep_sync[2]) begin
            nxt_s.sleep_lvl = s_ff.sleep_sync[2];
        end
        if (s_ff.act_sync[1] == s_ff.act_sync[2]) begin
            nxt_s.act_lvl = s_ff.act_sync[2];
        end
        mclk_edge = (s_ff.mclk_sync[1] == s_ff.mclk_sync[2])
            && (s_ff.mclk_sync[2] != s_ff.mclk_lvl);

        // Needs clk_i at least four times the main clock rate to see edges
        if (s_ff.sleep_lvl) begin
            nxt_s.cnt = '0; // see [R3]
        end else if (mclk_edge || s_ff.fallback) begin
            nxt_s.cnt = '0;
        end else if (s_ff.cnt == CNT_LAST) begin
            nxt_s.cnt = '0;
            fail_evt = 1'b1;
            nxt_s.fallback = 1'b1; // see [R1]
        end else begin
            nxt_s.cnt = s_ff.cnt + 1'b1;
        end
        nxt_s.nmi = fail_evt; // see [R2]

        // Divider switch takes the pending trim, then clears itself
        nxt_s.div_switch = s_ff.divsw;
        if (s_ff.divsw) begin
            nxt_s.trim_applied = s_ff.trim_reg; // see [R5]
            nxt_s.divsw = 1'b0;
        end

        if (wr && adr_i == TRIM_OFS) begin
            nxt_s.trim_reg = trim_new[TRIM_LSB +: TRIM_W]; // see [R4]
            if (!s_ff.on) begin
                nxt_s.trim_applied = trim_new[TRIM_LSB +: TRIM_W]; // see [R5]
            end
            viol_evt = (s_ff.on != s_ff.act_lvl); // see [R6]
        end
        if (wr && adr_i == CTRL_OFS) begin
            nxt_s.div = ctrl_new[CTRL_DIV_LSB +: DIV_W];
            nxt_s.on = ctrl_new[CTRL_ON_BIT];
            if (ctrl_new[CTRL_DIVSW_BIT]) begin
                nxt_s.divsw = 1'b1;
            end
            if (sel_i[0] && dat_i[CTRL_RESTORE_BIT] && !fail_evt) begin
                nxt_s.fallback = 1'b0;
            end
        end
        if (wr && adr_i == STAT_OFS) begin
            w1c = dat_i[EVT_W-1:0] & {EVT_W{sel_i[0]}};
        end
        if (wr && adr_i == MASK_OFS && sel_i[0]) begin
            nxt_s.mask = dat_i[EVT_W-1:0];
        end

        // Zero divisor means the output bypasses the divider and trim
        nxt_s.trim_out = (nxt_s.div == '0) ? '0 : nxt_s.trim_applied; // see [R7]

        // Set wins over a same-cycle clear
        evt = '0;
        evt[STAT_FAIL_BIT] = fail_evt;
        evt[STAT_VIOL_BIT] = viol_evt;
        nxt_s.status = (s_ff.status & ~w1c) | evt;
        nxt_s.irq = |(nxt_s.status & nxt_s.mask);

        nxt_s.ack = req;
        nxt_s.dat = 32'h0000_0000;
        if (req && !we_i) begin
            unique case (adr_i)
                TRIM_OFS: nxt_s.dat = trim_img; // see [R4]
                CTRL_OFS: begin
                    nxt_s.dat = ctrl_img;
                    nxt_s.dat[CTRL_ACTIVE_BIT] = s_ff.act_lvl;
                    nxt_s.dat[CTRL_FALLBACK_BIT] = s_ff.fallback;
                end
                STAT_OFS: nxt_s.dat[EVT_W-1:0] = s_ff.status;
                MASK_OFS: nxt_s.dat[EVT_W-1:0] = s_ff.mask;
                default: nxt_s.dat = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_ff <= '0;
            s_ff.trim_reg <= TRIM_RST;
            s_ff.trim_applied <= TRIM_RST;
            s_ff.trim_out <= TRIM_RST;
            s_ff.div <= DIV_RST;
            s_ff.status <= EVT_RST;
            s_ff.mask <= EVT_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign dat_o = s_ff.dat;
    assign ack_o = s_ff.ack;
    assign clk_sel_frc_o = s_ff.fallback;
    assign nmi_o = s_ff.nmi;
    assign irq_o = s_ff.irq;
    assign ref_on_o = s_ff.on;
    assign ref_div_o = s_ff.div;
    assign ref_trim_o = s_ff.trim_out;
    assign ref_div_switch_o = s_ff.div_switch;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_fail_switch;
        (!s_ff.sleep_lvl && !s_ff.fallback && s_ff.cnt == CNT_LAST
            && !mclk_edge) |=> clk_sel_frc_o;
    endproperty
    a_fail_switch: assert property (p_fail_switch) // see [R1]
        else $error("fallback not taken after clock stop");

    property p_nmi_with_switch;
        $rose(clk_sel_frc_o) |-> nmi_o ##1 !nmi_o;
    endproperty
    a_nmi_with_switch: assert property (p_nmi_with_switch) // see [R2]
        else $error("nmi missing or too long at switchover");

    property p_sleep_halt;
        s_ff.sleep_lvl && !s_ff.fallback |=> !clk_sel_frc_o && !nmi_o;
    endproperty
    a_sleep_halt: assert property (p_sleep_halt) // see [R3]
        else $error("switchover during sleep");

    property p_trim_read;
        (req && !we_i && adr_i == TRIM_OFS) |=> ack_o
            && dat_o[TRIM_LSB-1:0] == '0
            && dat_o[31:TRIM_LSB] == $past(s_ff.trim_reg);
    endproperty
    a_trim_read: assert property (p_trim_read) // see [R4]
        else $error("trim read data wrong");

    property p_trim_hold;
        (s_ff.on && !s_ff.divsw) |=> s_ff.trim_applied
            == $past(s_ff.trim_applied);
    endproperty
    a_trim_hold: assert property (p_trim_hold) // see [R5]
        else $error("trim applied without divider switch");

    property p_div_zero;
        (ref_div_o == '0) |-> ref_trim_o == '0;
    endproperty
    a_div_zero: assert property (p_div_zero) // see [R7]
        else $error("trim active with zero divisor");

    c_fail: cover property ($rose(clk_sel_frc_o));
    c_switch: cover property (ref_div_switch_o && ref_on_o);
    c_viol: cover property ($rose(s_ff.status[STAT_VIOL_BIT]));
endmodule

/* File: core/clock_fail_monitor_ref_trim_pkg.sv */
// Constants, register map and state type of the clock monitor and trim block
package clock_fail_monitor_ref_trim_pkg;
    localparam logic [3:0] TRIM_OFS = 4'h0;
    localparam logic [3:0] CTRL_OFS = 4'h4;
    localparam logic [3:0] STAT_OFS = 4'h8;
    localparam logic [3:0] MASK_OFS = 4'hC;

    localparam int TRIM_W = 9;
    localparam int TRIM_LSB = 23;
    localparam int DIV_W = 15;
    localparam int CTRL_DIV_LSB = 16;
    localparam int CTRL_ON_BIT = 15;
    localparam int CTRL_DIVSW_BIT = 9;
    localparam int CTRL_ACTIVE_BIT = 8;
    localparam int CTRL_FALLBACK_BIT = 1;
    localparam int CTRL_RESTORE_BIT = 0;

    localparam int EVT_W = 2;
    localparam int STAT_FAIL_BIT = 0;
    localparam int STAT_VIOL_BIT = 1;

    localparam int CNT_W = 16;
    localparam int FAIL_TIMEOUT_DEF = 64;

    localparam logic [TRIM_W-1:0] TRIM_RST = 9'h000;
    localparam logic [DIV_W-1:0] DIV_RST = 15'h0000;
    localparam logic [EVT_W-1:0] EVT_RST = 2'h0;

    typedef struct packed {
        logic [2:0] mclk_sync;
        logic mclk_lvl;
        logic [2:0] sleep_sync;
        logic sleep_lvl;
        logic [2:0] act_sync;
        logic act_lvl;
        logic [CNT_W-1:0] cnt;
        logic fallback;
        logic nmi;
        logic [TRIM_W-1:0] trim_reg;
        logic [TRIM_W-1:0] trim_applied;
        logic [TRIM_W-1:0] trim_out;
        logic on;
        logic divsw;
        logic div_switch;
        logic [DIV_W-1:0] div;
        logic [EVT_W-1:0] status;
        logic [EVT_W-1:0] mask;
        logic irq;
        logic ack;
        logic [31:0] dat;
    } state_t;
endpackage

/* File: test/testbench.sv */
// Self-checking bench for the clock monitor and reference trim block
module testbench
    import clock_fail_monitor_ref_trim_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [3:0] adr_i = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000;
    logic [3:0] sel_i = 4'hF;
    logic [3:0] sel_v = 4'hF;
    logic main_clk_i = 1'b0;
    logic sleep_i = 1'b0;
    logic ref_active_i = 1'b0;
    logic mclk_run = 1'b1;
    logic [31:0] dat_o, rd;
    logic ack_o, clk_sel_frc_o, nmi_o, irq_o, ref_on_o, ref_div_switch_o;
    logic [DIV_W-1:0] ref_div_o;
    logic [TRIM_W-1:0] ref_trim_o;
    int error_cnt = 0;
    int compares = 0;
    int cyc_cnt = 0;
    int nmi_n = 0;
    int sw_n = 0;

    clock_fail_monitor_ref_trim #(.FAIL_TIMEOUT(16)) DUT (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .main_clk_i(main_clk_i),
        .sleep_i(sleep_i), .ref_active_i(ref_active_i),
        .clk_sel_frc_o(clk_sel_frc_o), .nmi_o(nmi_o), .irq_o(irq_o),
        .ref_on_o(ref_on_o), .ref_div_o(ref_div_o),
        .ref_trim_o(ref_trim_o), .ref_div_switch_o(ref_div_switch_o)
    );

    always #2 clk_i = ~clk_i;

    // Main clock kept slow: the monitor needs it at most a quarter of clk_i
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (nmi_o === 1'b1) nmi_n++;
        if (ref_div_switch_o === 1'b1) sw_n++;
        if (mclk_run && cyc_cnt % 4 == 0) main_clk_i <= ~main_clk_i;
        if (cyc_cnt == 4000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (error_cnt == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One classic cycle; read data is taken at the ack edge only
    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= sel_v;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0000_0000);
        check(rd, exp);
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    function automatic logic [31:0] ctl(input logic [14:0] dv,
                                        input logic on, sw, rs);
        return (32'(dv) << CTRL_DIV_LSB) | (32'(on) << CTRL_ON_BIT)
            | (32'(sw) << CTRL_DIVSW_BIT) | (32'(rs) << CTRL_RESTORE_BIT);
    endfunction

    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        wait_n(4);
        rdchk(TRIM_OFS, 32'h0000_0000);
        wb(1'b1, TRIM_OFS, 32'hFFFF_FFFF);
        rdchk(TRIM_OFS, 32'hFF80_0000);
        wait_n(2);
        check(32'(ref_trim_o), 32'h0000_0000);
        wb(1'b1, CTRL_OFS, ctl(15'h0005, 1'b0, 1'b0, 1'b0));
        wait_n(2);
        check(32'(ref_trim_o), 32'h0000_01FF);
        @(posedge clk_i);
        ref_active_i <= 1'b1;
        wb(1'b1, CTRL_OFS, ctl(15'h0005, 1'b1, 1'b0, 1'b0));
        wait_n(6);
        rdchk(CTRL_OFS, 32'h0005_8100);
        // Held while on: only the switch request may apply it
        wb(1'b1, TRIM_OFS, 32'h5580_0000);
        wait_n(3);
        check(32'(ref_trim_o), 32'h0000_01FF);
        rdchk(4'h1, 32'h0000_0000);
        wb(1'b1, CTRL_OFS, ctl(15'h0005, 1'b1, 1'b1, 1'b0));
        wait_n(3);
        check(32'(ref_trim_o), 32'h0000_00AB);
        check(32'(sw_n), 32'h0000_0001);
        check(32'({ref_on_o, ref_div_o}), 32'h0000_8005);
        // Software slip: trim written while enable and active differ
        @(posedge clk_i);
        ref_active_i <= 1'b0;
        wait_n(5);
        wb(1'b1, TRIM_OFS, 32'h0000_0000);
        rdchk(STAT_OFS, 32'h0000_0002);
        check(32'(irq_o), 32'h0000_0000);
        wb(1'b1, MASK_OFS, 32'h0000_0003);
        wait_n(2);
        check(32'(irq_o), 32'h0000_0001);
        // Byte lane 0 off: the mask write must be ignored
        sel_v = 4'h0;
        wb(1'b1, MASK_OFS, 32'h0000_0000);
        sel_v = 4'hF;
        rdchk(MASK_OFS, 32'h0000_0003);
        wb(1'b1, STAT_OFS, 32'h0000_0002);
        wait_n(2);
        check(32'(irq_o), 32'h0000_0000);
        check(32'(clk_sel_frc_o), 32'h0000_0000);
        // Stop the main clock while asleep: nothing may fire
        @(posedge clk_i);
        sleep_i <= 1'b1;
        wait_n(6);
        @(posedge clk_i);
        mclk_run <= 1'b0;
        wait_n(60);
        check(32'(clk_sel_frc_o), 32'h0000_0000);
        check(32'(nmi_n), 32'h0000_0000);
        @(posedge clk_i);
        sleep_i <= 1'b0;
        wait_n(40);
        check(32'(clk_sel_frc_o), 32'h0000_0001);
        check(32'(nmi_n), 32'h0000_0001);
        rdchk(STAT_OFS, 32'h0000_0001);
        rdchk(CTRL_OFS, 32'h0005_8002);
        check(32'(irq_o), 32'h0000_0001);
        @(posedge clk_i);
        mclk_run <= 1'b1;
        wait_n(8);
        wb(1'b1, CTRL_OFS, ctl(15'h0005, 1'b1, 1'b0, 1'b1));
        wb(1'b1, STAT_OFS, 32'h0000_0001);
        wait_n(20);
        check(32'(clk_sel_frc_o), 32'h0000_0000);
        check(32'(irq_o), 32'h0000_0000);
        check(32'(nmi_n), 32'h0000_0001);
        tally_and_finish();
    end
endmodule
